// *** include/tlmps_defs.vh ***
// Constants of the telemetry priority scheduler: command codes, field
// positions, tier codes, reset values and state codes.
// Assumes inclusion by bare name from the hdl/ sources.
`ifndef TLMPS_DEFS_VH
`define TLMPS_DEFS_VH

// Command codes seen on the command port
`define TLMPS_CMD_CFG 8'hD0
`define TLMPS_CMD_RD_VIN 8'h88
`define TLMPS_CMD_RD_VOUT 8'h8B
`define TLMPS_CMD_RD_IOUT 8'h8C
`define TLMPS_CMD_RD_TEMP 8'h8D

// Block lengths in bytes
`define TLMPS_CFG_LEN 8'h06
`define TLMPS_TELE_LEN 8'h02
`define TLMPS_NO_LEN 8'h00

// Configuration layout: each channel owns one byte, lowest byte first
`define TLMPS_CFG_W 40
`define TLMPS_TOP_BYTE 8'h00
`define TLMPS_CH_BYTE_W 8
`define TLMPS_PRI_LSB 6
`define TLMPS_AVG_LSB 0
`define TLMPS_AVG_W 3

// Channel numbers, equal to the byte index of their fields
`define TLMPS_CH_VOUT 2'h0
`define TLMPS_CH_IOUT 2'h1
`define TLMPS_CH_TEMP 2'h2
`define TLMPS_CH_VIN 2'h3

// Priority tier codes
`define TLMPS_TIER_A 2'h0
`define TLMPS_TIER_B 2'h1
`define TLMPS_TIER_C 2'h2
`define TLMPS_TIER_OFF 2'h3

// Largest valid averaging exponent
`define TLMPS_AVG_MAX 3'h5

// Configuration before nonvolatile load: all tiers A, depth 1, byte 4 = 03h
`define TLMPS_CFG_RST 40'h03_00_00_00_00

// Scheduler phases and states
`define TLMPS_PH_A 2'h0
`define TLMPS_PH_B 2'h1
`define TLMPS_PH_C 2'h2
`define TLMPS_ST_PICK 2'h0
`define TLMPS_ST_CONV 2'h1
`define TLMPS_ST_UPD 2'h2

`endif

// *** hdl/tlmps_hist_mem.v ***
// Sample history memory of the telemetry averager, one region per channel.
// Assumes one clock, synchronous reset and a common clock enable.
module tlmps_hist_mem #(
   parameter DW = 16,
   parameter AW = 7
) (
   input wire clk, // System clock
   input wire ce, // Clock enable
   input wire rd_en, // Read request
   input wire [AW-1:0] rd_addr, // Read address
   output reg [DW-1:0] rd_data, // Registered read data
   input wire wr_en, // Write request
   input wire [AW-1:0] wr_addr, // Write address
   input wire [DW-1:0] wr_data // Write data
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         if (rd_en) begin
            rd_data <= mem[rd_addr];
         end
      end
   end
endmodule

// *** hdl/tlmps_avg_unit.v ***
// Rolling-average arithmetic for one new sample.
// Assumes the caller has already zeroed sum and fill after a depth change.
`include "tlmps_defs.vh"
module tlmps_avg_unit #(
   parameter SW = 16,
   parameter FW = 6
) (
   input wire [SW+4:0] sum_in, // Running sum of the window
   input wire [FW-1:0] fill_in, // Samples held so far
   input wire [SW-1:0] sample, // Newest sample
   input wire [SW-1:0] oldest, // Sample leaving the window
   input wire [2:0] depth, // Averaging exponent
   output wire [SW+4:0] sum_out, // Updated running sum
   output wire [FW-1:0] fill_out, // Updated fill count
   output wire [SW-1:0] avg_out // Reported average
);
   wire [2:0] n = (depth > `TLMPS_AVG_MAX) ? `TLMPS_AVG_MAX : depth;
   wire [FW-1:0] len = {{(FW-1){1'b0}}, 1'b1} << n;
   wire full_in = (fill_in >= len);
   wire [SW+4:0] sub = full_in ? {5'h00, oldest} : {(SW+5){1'b0}};
   wire [SW+4:0] shifted;

   assign sum_out = sum_in + {5'h00, sample} - sub;
   assign fill_out = full_in ? fill_in : fill_in + {{(FW-1){1'b0}}, 1'b1};
   assign shifted = sum_out >> n;
   // Until the window is full the newest sample stands in for the average
   assign avg_out = (fill_out >= len) ? shifted[SW-1:0] : sample;
endmodule

// *** hdl/tlmps_top.v ***
// Telemetry priority scheduler: configuration command, tiered ADC rotation,
// per-channel rolling averages and telemetry read-back.
// Assumes a command-level front end that has already framed block transfers,
// an ADC that answers each start pulse with one done pulse, and NVM data
// presented on nvm_valid after power-up.
`include "tlmps_defs.vh"

// Summary of operation
// (RL1) One ADC; all tier A channels first
// (RL2) One tier B sample per tier A pass
// (RL3) One tier C sample per tier B pass
// (RL4) Input voltage tier field, 11b disables
// (RL5) Input voltage average over 2^N samples
// (RL6) Temperature tier field; 11b invalid
// (RL7) Temperature average over 2^N samples
// (RL8) Output current tier field, 11b disables
// (RL9) Output current average over 2^N samples
// (RL10) Output voltage tier field, 11b disables
// (RL11) Output voltage average over 2^N samples
// (RL12) Disabled channel reads back zero
// (RL13) Temperature can never be disabled
// (RL14) Top byte reads zero, host writes 00h
// (RL15) Host writes 03h into byte four
// (RL16) Host writes reserved gaps as zero
// (RL17) Config command uses six-byte blocks only
// (RL18) NVM load at power-up; changes apply next pass
// (RL19) Empty tiers and disabled channels take no slot
module tlmps_top #(
   parameter SW = 16,
   parameter HAW = 5
) (
   input wire clk, // System clock, 100 MHz
   input wire rst_n, // Synchronous reset, active low
   input wire ce, // Clock enable, freezes all state when low
   input wire nvm_valid, // Stored configuration is available
   input wire [`TLMPS_CFG_W-1:0] nvm_cfg, // Stored configuration bits 39:0
   input wire cmd_valid, // Command request strobe
   input wire cmd_write, // 1 = block write, 0 = read
   input wire [7:0] cmd_code, // Command code
   input wire [7:0] cmd_len, // Write byte count
   input wire [47:0] cmd_wdata, // Write data, first byte in bits 7:0
   output reg resp_valid, // Answer strobe
   output reg resp_ok, // Command accepted
   output reg [7:0] resp_len, // Read byte count
   output reg [47:0] resp_rdata, // Read data
   output reg adc_start, // Start one conversion
   output reg [1:0] adc_chan, // Channel to convert
   input wire adc_done, // Conversion finished
   input wire [SW-1:0] adc_data // Conversion result
);
   localparam FW = HAW + 1;
   localparam AW = HAW + 2;

   reg [`TLMPS_CFG_W-1:0] cfg_q;
   reg [`TLMPS_CFG_W-1:0] snap_q;
   reg loaded_q;
   reg [1:0] phase_q;
   reg [1:0] st_q;
   reg [2:0] a_idx_q;
   reg [1:0] b_ptr_q;
   reg [1:0] c_ptr_q;
   reg c_due_q;
   reg [SW-1:0] sample_q;
   reg [SW+4:0] sum_q [0:3];
   reg [FW-1:0] fill_q [0:3];
   reg [HAW-1:0] ptr_q [0:3];
   reg [2:0] depth_q [0:3];
   reg [SW-1:0] avg_q [0:3];
   integer i;

   // Tier of a channel in a configuration image
   function [1:0] tier_of;
      input [`TLMPS_CFG_W-1:0] cfg;
      input [1:0] ch;
      reg [1:0] t;
      begin
         t = cfg[ch*`TLMPS_CH_BYTE_W+`TLMPS_PRI_LSB +: 2];
         // Temperature stays scheduled whatever is written
         if (ch == `TLMPS_CH_TEMP && t == `TLMPS_TIER_OFF) begin // [RL13] [RL6]
            t = `TLMPS_TIER_C;
         end
         tier_of = t;
      end
   endfunction

   // First member of mask at or above start; bit 2 flags a hit
   function [2:0] find_from;
      input [3:0] mask;
      input [2:0] start;
      integer k;
      begin
         find_from = 3'h0;
         for (k = 3; k >= 0; k = k - 1) begin
            if (mask[k] && k >= start) begin
               find_from = {1'b1, k[1:0]};
            end
         end
      end
   endfunction

   // Cyclic search starting at ptr
   function [2:0] find_cyc;
      input [3:0] mask;
      input [1:0] ptr;
      reg [2:0] f;
      begin
         f = find_from(mask, {1'b0, ptr});
         if (!f[2]) begin
            f = find_from(mask, 3'h0);
         end
         find_cyc = f;
      end
   endfunction

   // Tier masks of the active pass; live_off flags disabled channels of the live configuration
   wire [3:0] mask_a;
   wire [3:0] mask_b;
   wire [3:0] mask_c;
   wire [3:0] live_off;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_mask
         assign mask_a[g] = (tier_of(snap_q, g) == `TLMPS_TIER_A); // [RL4] [RL8] [RL10]
         assign mask_b[g] = (tier_of(snap_q, g) == `TLMPS_TIER_B);
         assign mask_c[g] = (tier_of(snap_q, g) == `TLMPS_TIER_C);
         assign live_off[g] = (tier_of(cfg_q, g) == `TLMPS_TIER_OFF);
      end
   endgenerate

   wire [2:0] fa = find_from(mask_a, a_idx_q); // [RL1]
   wire [2:0] fb = find_cyc(mask_b, b_ptr_q);
   wire [2:0] fb_rest = find_from(mask_b, {1'b0, fb[1:0]} + 3'h1);
   wire [2:0] fc = find_cyc(mask_c, c_ptr_q);

   // Averaging depth of the channel being converted
   wire [2:0] cur_depth = snap_q[adc_chan*`TLMPS_CH_BYTE_W+`TLMPS_AVG_LSB +: `TLMPS_AVG_W];
   wire [2:0] clamp_depth = (cur_depth > `TLMPS_AVG_MAX) ? `TLMPS_AVG_MAX : cur_depth;
   wire depth_chg = (clamp_depth != depth_q[adc_chan]);
   wire [HAW-1:0] old_ptr = ptr_q[adc_chan] - ({{(HAW-1){1'b0}}, 1'b1} << clamp_depth);

   wire mem_rd_en = (st_q == `TLMPS_ST_CONV) && adc_done;
   wire mem_we = (st_q == `TLMPS_ST_UPD);
   wire [SW-1:0] mem_rdata;

   tlmps_hist_mem #(.DW(SW), .AW(AW)) u_mem (
      .clk(clk),
      .ce(ce),
      .rd_en(mem_rd_en),
      .rd_addr({adc_chan, old_ptr}),
      .rd_data(mem_rdata),
      .wr_en(mem_we),
      .wr_addr({adc_chan, ptr_q[adc_chan]}),
      .wr_data(sample_q)
   );

   wire [SW+4:0] sum_next;
   wire [FW-1:0] fill_next;
   wire [SW-1:0] avg_next;

   // A changed depth restarts the window from empty
   tlmps_avg_unit #(.SW(SW), .FW(FW)) u_avg (
      .sum_in(depth_chg ? {(SW+5){1'b0}} : sum_q[adc_chan]),
      .fill_in(depth_chg ? {FW{1'b0}} : fill_q[adc_chan]),
      .sample(sample_q),
      .oldest(mem_rdata),
      .depth(clamp_depth), // [RL5] [RL7] [RL9] [RL11]
      .sum_out(sum_next),
      .fill_out(fill_next),
      .avg_out(avg_next)
   );

   // Telemetry word for a read command
   function [SW-1:0] tele_val;
      input [1:0] ch;
      input [3:0] off;
      input [SW-1:0] val;
      begin
         tele_val = off[ch] ? {SW{1'b0}} : val; // [RL12]
      end
   endfunction

   always @(posedge clk) begin
      if (!rst_n) begin
         cfg_q <= `TLMPS_CFG_RST;
         snap_q <= `TLMPS_CFG_RST;
         loaded_q <= 1'b0;
         phase_q <= `TLMPS_PH_A;
         st_q <= `TLMPS_ST_PICK;
         a_idx_q <= 3'h0;
         b_ptr_q <= 2'h0;
         c_ptr_q <= 2'h0;
         c_due_q <= 1'b0;
         sample_q <= {SW{1'b0}};
         resp_valid <= 1'b0;
         resp_ok <= 1'b0;
         resp_len <= `TLMPS_NO_LEN;
         resp_rdata <= 48'h0000_0000_0000;
         adc_start <= 1'b0;
         adc_chan <= 2'h0;
         for (i = 0; i < 4; i = i + 1) begin
            sum_q[i] <= {(SW+5){1'b0}};
            fill_q[i] <= {FW{1'b0}};
            ptr_q[i] <= {HAW{1'b0}};
            depth_q[i] <= 3'h0;
            avg_q[i] <= {SW{1'b0}};
         end
      end else if (ce) begin
         adc_start <= 1'b0;
         resp_valid <= 1'b0;

         // Power-up load of the stored configuration
         if (!loaded_q && nvm_valid) begin // [RL18]
            cfg_q <= nvm_cfg;
            snap_q <= nvm_cfg;
            loaded_q <= 1'b1;
         end

         // Command port
         if (cmd_valid) begin
            resp_valid <= 1'b1;
            resp_ok <= 1'b0;
            resp_len <= `TLMPS_NO_LEN;
            resp_rdata <= 48'h0000_0000_0000;
            case (cmd_code)
               `TLMPS_CMD_CFG: begin
                  if (cmd_write) begin
                     // Only a six-byte block is taken; top byte is not stored
                     if (cmd_len == `TLMPS_CFG_LEN) begin // [RL17] [RL14]
                        cfg_q <= cmd_wdata[`TLMPS_CFG_W-1:0];
                        resp_ok <= 1'b1;
                     end
                  end else begin
                     resp_ok <= 1'b1;
                     resp_len <= `TLMPS_CFG_LEN; // [RL17]
                     resp_rdata <= {`TLMPS_TOP_BYTE, cfg_q}; // [RL14]
                  end
               end
               `TLMPS_CMD_RD_VOUT, `TLMPS_CMD_RD_IOUT,
               `TLMPS_CMD_RD_TEMP, `TLMPS_CMD_RD_VIN: begin
                  if (!cmd_write) begin
                     resp_ok <= 1'b1;
                     resp_len <= `TLMPS_TELE_LEN;
                     case (cmd_code)
                        `TLMPS_CMD_RD_VOUT: resp_rdata <= {32'h0000_0000,
                           tele_val(`TLMPS_CH_VOUT, live_off, avg_q[0])};
                        `TLMPS_CMD_RD_IOUT: resp_rdata <= {32'h0000_0000,
                           tele_val(`TLMPS_CH_IOUT, live_off, avg_q[1])};
                        `TLMPS_CMD_RD_TEMP: resp_rdata <= {32'h0000_0000,
                           tele_val(`TLMPS_CH_TEMP, live_off, avg_q[2])};
                        default: resp_rdata <= {32'h0000_0000,
                           tele_val(`TLMPS_CH_VIN, live_off, avg_q[3])};
                     endcase
                  end
               end
               default: begin
                  resp_ok <= 1'b0;
               end
            endcase
         end

         // Scheduler
         case (st_q)
            `TLMPS_ST_PICK: begin
               if (loaded_q) begin
                  case (phase_q)
                     `TLMPS_PH_A: begin
                        if (fa[2]) begin // [RL1]
                           adc_start <= 1'b1;
                           adc_chan <= fa[1:0];
                           a_idx_q <= {1'b0, fa[1:0]} + 3'h1;
                           st_q <= `TLMPS_ST_CONV;
                        end else begin
                           a_idx_q <= 3'h0;
                           phase_q <= `TLMPS_PH_B;
                        end
                     end
                     `TLMPS_PH_B: begin
                        // A finished B pass hands the next B slot to tier C
                        if (mask_b == 4'h0 || (c_due_q && mask_c != 4'h0)) begin // [RL19]
                           c_due_q <= 1'b0;
                           if (mask_c != 4'h0) begin
                              adc_start <= 1'b1; // [RL3]
                              adc_chan <= fc[1:0];
                              c_ptr_q <= fc[1:0] + 2'h1;
                              st_q <= `TLMPS_ST_CONV;
                           end
                        end else begin
                           adc_start <= 1'b1; // [RL2]
                           adc_chan <= fb[1:0];
                           b_ptr_q <= fb[1:0] + 2'h1;
                           st_q <= `TLMPS_ST_CONV;
                           c_due_q <= !fb_rest[2];
                        end
                        phase_q <= `TLMPS_PH_A;
                        snap_q <= cfg_q; // [RL18]
                     end
                     default: begin
                        phase_q <= `TLMPS_PH_A;
                     end
                  endcase
               end
            end
            `TLMPS_ST_CONV: begin
               if (adc_done) begin
                  sample_q <= adc_data;
                  st_q <= `TLMPS_ST_UPD;
               end
            end
            `TLMPS_ST_UPD: begin
               sum_q[adc_chan] <= sum_next; // [RL5] [RL7] [RL9] [RL11]
               fill_q[adc_chan] <= fill_next;
               avg_q[adc_chan] <= avg_next;
               depth_q[adc_chan] <= clamp_depth;
               ptr_q[adc_chan] <= ptr_q[adc_chan] + {{(HAW-1){1'b0}}, 1'b1};
               st_q <= `TLMPS_ST_PICK;
            end
            default: begin
               st_q <= `TLMPS_ST_PICK;
            end
         endcase
      end
   end
endmodule

// *** testbench/tlmps_chk_asserts.sv ***
// Port checker for the telemetry scheduler top module.
// Assumes ce stays high while commands and conversions run.
`include "tlmps_defs.vh"
module tlmps_chk #(
   parameter SW = 16,
   parameter HAW = 5
) (
   input wire clk, // Clock
   input wire rst_n, // Reset, active low
   input wire ce, // Enable
   input wire nvm_valid, // Stored config ready
   input wire [`TLMPS_CFG_W-1:0] nvm_cfg, // Stored config
   input wire cmd_valid, // Request
   input wire cmd_write, // Write
   input wire [7:0] cmd_code, // Code
   input wire [7:0] cmd_len, // Length
   input wire [47:0] cmd_wdata, // Write data
   input wire resp_valid, // Answer
   input wire resp_ok, // Accepted
   input wire [7:0] resp_len, // Read length
   input wire [47:0] resp_rdata, // Read data
   input wire adc_start, // Start
   input wire [1:0] adc_chan, // Channel
   input wire adc_done, // Done
   input wire [SW-1:0] adc_data // Result
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [39:0] cfg_q;
   reg ld_q;
   reg [4:0] gap_q;
   wire rd_cmd = cmd_valid && ce && !cmd_write;
   wire off_rd = rd_cmd && (cmd_code == 8'h88 && cfg_q[31:30] == 2'h3
      || cmd_code == 8'h8B && cfg_q[7:6] == 2'h3 || cmd_code == 8'h8C && cfg_q[15:14] == 2'h3);
   // Live config copy and conversions since the last temperature sample
   always @(posedge clk) begin
      if (!rst_n) begin
         cfg_q <= `TLMPS_CFG_RST;
         ld_q <= 1'b0;
         gap_q <= 5'h00;
      end else if (ce) begin
         if (!ld_q && nvm_valid) begin
            cfg_q <= nvm_cfg;
            ld_q <= 1'b1;
         end else if (cmd_valid && cmd_write && cmd_code == 8'hD0 && cmd_len == 8'h06) begin
            cfg_q <= cmd_wdata[39:0];
         end
         if (adc_start) begin
            gap_q <= (adc_chan == 2'h2) ? 5'h00 : gap_q + 5'h01;
         end
      end
   end
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_cfg_rd;
      rd_cmd && cmd_code == 8'hD0;
   endsequence
   sequence s_quiet3;
      !adc_start [*3];
   endsequence
   a_resp_follows: assert property (cmd_valid && ce |=> resp_valid)
      else $error("command without answer");
   a_resp_cause: assert property (resp_valid |-> $past(cmd_valid && ce))
      else $error("answer without command");
   a_cfg_read: assert property (s_cfg_rd |=> resp_ok && resp_len == 8'h06
      && resp_rdata == {8'h00, cfg_q}) else $error("config read wrong");
   a_short_refused: assert property (cmd_valid && ce && cmd_write
      && cmd_code == 8'hD0 && cmd_len != 8'h06 |=> !resp_ok) else $error("short block taken");
   a_conv_spacing: assert property (adc_start |=> s_quiet3)
      else $error("conversions overlap");
   a_done_gap: assert property (adc_done |-> s_quiet3)
      else $error("start too soon after done");
   a_off_zero: assert property (off_rd |=> resp_len == 8'h02
      && resp_rdata[15:0] == 16'h0000) else $error("disabled channel not zero");
   a_temp_kept: assert property (gap_q <= 5'h0C)
      else $error("temperature left out");
endmodule

bind tlmps_top tlmps_chk #(.SW(SW), .HAW(HAW)) chk_u (.clk(clk), .rst_n(rst_n), .ce(ce),
   .nvm_valid(nvm_valid), .nvm_cfg(nvm_cfg), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
   .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
   .resp_ok(resp_ok), .resp_len(resp_len), .resp_rdata(resp_rdata), .adc_start(adc_start),
   .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data));

// *** testbench/tlmps_adc_model.sv ***
// Behavioural converter answering the scheduler's start pulses.
// Assumes one clock; vals gives the result returned for each channel.
module tlmps_adc_model (
   input logic clk, // Clock
   input logic rst_n, // Reset, active low
   input logic adc_start, // Start pulse
   input logic [1:0] adc_chan, // Channel
   input logic [3:0] lat, // Extra cycles before done
   input logic [15:0] vals [4], // Result per channel
   output logic adc_done, // Done pulse
   output logic [15:0] adc_data // Result, valid with done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_q;
   logic [3:0] cnt_q;
   logic [1:0] ch_q;
   initial begin
      adc_done = 1'b0;
      adc_data = 16'h5A5A;
   end
   always @(posedge clk) begin
      // Data changes every cycle outside the done cycle
      adc_data <= ~adc_data;
      adc_done <= 1'b0;
      if (!rst_n) begin
         busy_q <= 1'b0;
      end else if (adc_start) begin
         busy_q <= 1'b1;
         cnt_q <= lat;
         ch_q <= adc_chan;
      end else if (busy_q && cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
         busy_q <= 1'b0;
         adc_done <= 1'b1;
         adc_data <= vals[ch_q];
      end
   end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the telemetry scheduler.
// Assumes the converter model and the bound port checker.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, ce, nvm_valid, cmd_valid, cmd_write, resp_valid, resp_ok;
   logic adc_start, adc_done;
   logic [39:0] nvm_cfg;
   logic [7:0] cmd_code, cmd_len, resp_len;
   logic [47:0] cmd_wdata, resp_rdata;
   logic [1:0] adc_chan;
   logic [15:0] adc_data;
   logic [15:0] vals [4];
   logic [3:0] lat;
   logic [1:0] seen [$];
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   tlmps_top #(.SW(16), .HAW(5)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
      .nvm_valid(nvm_valid), .nvm_cfg(nvm_cfg), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
      .resp_ok(resp_ok), .resp_len(resp_len), .resp_rdata(resp_rdata), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data));
   tlmps_adc_model adc_u (.clk(clk), .rst_n(rst_n), .adc_start(adc_start),
      .adc_chan(adc_chan), .lat(lat), .vals(vals), .adc_done(adc_done), .adc_data(adc_data));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (adc_start === 1'b1) seen.push_back(adc_chan);
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] l,
      input logic [47:0] d);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_code <= c;
      cmd_len <= l;
      cmd_wdata <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      chk(resp_valid, 1'b1);
   endtask
   task automatic wait_n(input int n);
      seen.delete();
      for (int i = 0; i < 500 && seen.size() < n; i++) @(posedge clk);
      chk(seen.size() >= n, 1'b1);
   endtask
   task automatic wait_vout_done();
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 200 && !hit; i++) begin
         @(posedge clk);
         hit = (adc_done === 1'b1 && adc_chan === 2'h0);
      end
      chk(hit, 1'b1);
   endtask
   task automatic t_boot();
      logic [15:0] ord;
      ord = 16'h8484;
      cmd(1'b0, 8'hD0, 8'h06, 48'h0);
      chk(resp_rdata, 48'h00_03_00_00_00_00);
      @(posedge clk);
      nvm_valid <= 1'b1;
      wait_n(8);
      for (int i = 0; i < 8; i++) chk(seen[i], ord[2*i +: 2]);
      cmd(1'b0, 8'hD0, 8'h06, 48'h0);
      chk(resp_rdata, {8'h00, nvm_cfg});
      cmd(1'b0, 8'h88, 8'h00, 48'h0);
      chk({resp_len, resp_rdata[15:0]}, 24'h02_0000);
   endtask
   task automatic t_avg();
      lat <= 4'h5;
      cmd(1'b1, 8'hD0, 8'h06, 48'h00_03_C0_80_40_01);
      chk(resp_ok, 1'b1);
      wait_n(12);
      wait_vout_done();
      vals[0] <= 16'h0300;
      wait_vout_done();
      repeat (2) @(posedge clk);
      cmd(1'b0, 8'h8B, 8'h00, 48'h0);
      chk(resp_rdata[15:0], 16'h0200);
   endtask
   task automatic t_off();
      cmd(1'b1, 8'hD0, 8'h06, 48'h00_03_00_40_C0_C0);
      cmd(1'b0, 8'h8B, 8'h00, 48'h0);
      chk({resp_len, resp_rdata[15:0]}, 24'h02_0000);
      cmd(1'b0, 8'h8C, 8'h00, 48'h0);
      chk({resp_len, resp_rdata[15:0]}, 24'h02_0000);
      wait_n(4);
      wait_n(6);
      for (int i = 0; i < 5; i++) begin
         chk(seen[i] != seen[i+1], 1'b1);
         chk(seen[i][1], 1'b1);
      end
      cmd(1'b0, 8'h88, 8'h00, 48'h0);
      chk(resp_rdata[15:0], 16'h0777);
      cmd(1'b0, 8'h8D, 8'h00, 48'h0);
      chk(resp_rdata[15:0], 16'h0ABC);
   endtask
   task automatic t_refuse();
      cmd(1'b1, 8'hD0, 8'h05, {48{1'b1}});
      chk(resp_ok, 1'b0);
      cmd(1'b1, 8'h8B, 8'h02, 48'h0);
      chk({resp_ok, resp_len}, 9'h000);
      cmd(1'b0, 8'h55, 8'h00, 48'h0);
      chk({resp_ok, resp_len}, 9'h000);
      cmd(1'b0, 8'hD0, 8'h06, 48'h0);
      chk(resp_rdata, 48'h00_03_00_40_C0_C0);
      cmd(1'b1, 8'hD0, 8'h06, 48'hFF_03_00_40_C0_C0);
      cmd(1'b0, 8'hD0, 8'h06, 48'h0);
      chk(resp_rdata, 48'h00_03_00_40_C0_C0);
   endtask
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      nvm_valid = 1'b0;
      nvm_cfg = 40'h03_C0_80_40_00;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_len = 8'h00;
      cmd_wdata = 48'h0;
      lat = 4'h0;
      vals = '{16'h0100, 16'h0055, 16'h0ABC, 16'h0777};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_boot();
      t_avg();
      t_off();
      t_refuse();
      report_and_stop();
   end
endmodule
